// ---- hw/tbc_event_irq.sv ----
// sticky event status, enable mask and interrupt level
`timescale 1ns/10ps
module tbc_event_irq (
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   input  wire logic [tbc_pkg::EVT_W-1:0]  events,
   input  wire logic                       clr_we,
   input  wire logic [tbc_pkg::EVT_W-1:0]  clr_data,
   input  wire logic                       en_we,
   input  wire logic [tbc_pkg::EVT_W-1:0]  en_data,
   output logic      [tbc_pkg::EVT_W-1:0]  status,
   output logic      [tbc_pkg::EVT_W-1:0]  enable,
   output logic                            irq
);
   logic [tbc_pkg::EVT_W-1:0] status_reg;
   logic [tbc_pkg::EVT_W-1:0] enable_reg;

   // a new event beats a clear in the same cycle
   genvar i;
   generate
      for (i = 0; i < tbc_pkg::EVT_W; i++) begin : g_stat
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               status_reg[i] <= 1'b0;
            end else begin
               status_reg[i] <= events[i] || (status_reg[i] && !(clr_we && clr_data[i]));
            end
         end
      end
   endgenerate

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable_reg <= tbc_pkg::EVT_RST;
      end else if (en_we) begin
         enable_reg <= en_data;
      end
   end

   assign status = status_reg;
   assign enable = enable_reg;
   assign irq    = |(status_reg & enable_reg);
endmodule : tbc_event_irq

// ---- hw/tbc_pkg.sv ----
// constants and register map of the timebase counter
// How it works
// - setting run resumes counting from the held count, never clearing it
// - the 8-bit count increments once per prescaler output tick
// - wrap from ff to 00 sets the rollover flag and may request interrupt
// - software may write the count anytime; counting continues from that value
// - chain bit set makes a 16-bit counter, this count as high byte
// - when chained, the auto-reload timer low byte wrap (ff on its clock) advances the counter, not the prescaler
// - bit 7 of control/status always reads 0; writes to it are ignored
// - bit 6 is the read/write chain enable: 0 independent, 1 chained
// - rollover flag in bit 5 set only by hardware, cleared by reading control/status
// - writing the rollover flag bit position leaves the flag unchanged
// - bit 4 is interrupt enable; when 1, interrupt requested while flag is 1
// - bit 3 is run: 0 freezes count and resets prescaler, 1 runs the count and, when not chained, the prescaler
// - divider codes 000 to 111 give division by 2 up to 256
// - reset clears count and control/status to 00, stopped, interrupt off
package tbc_pkg;
   localparam int unsigned DATA_W        = 8;
   localparam int unsigned DIV_W         = 3;
   localparam int unsigned PRESC_W       = 8;
   localparam int unsigned ADDR_W        = 8;
   localparam int unsigned EVT_W         = 2;

   // register indices; byte address is four times the index
   localparam logic [ADDR_W-1:0] COUNT_IDX  = 8'h36;
   localparam logic [ADDR_W-1:0] CSR_IDX    = 8'h37;
   localparam logic [ADDR_W-1:0] STAT_IDX   = 8'h38;
   localparam logic [ADDR_W-1:0] CLR_IDX    = 8'h39;
   localparam logic [ADDR_W-1:0] EN_IDX     = 8'h3a;
   localparam logic [ADDR_W-1:0] COUNT_ADDR = ADDR_W'(COUNT_IDX * 4);
   localparam logic [ADDR_W-1:0] CSR_ADDR   = ADDR_W'(CSR_IDX * 4);
   localparam logic [ADDR_W-1:0] STAT_ADDR  = ADDR_W'(STAT_IDX * 4);
   localparam logic [ADDR_W-1:0] CLR_ADDR   = ADDR_W'(CLR_IDX * 4);
   localparam logic [ADDR_W-1:0] EN_ADDR    = ADDR_W'(EN_IDX * 4);

   // control/status fields
   localparam int unsigned CSR_RSVD_BIT  = 7;
   localparam int unsigned CSR_CHAIN_BIT = 6;
   localparam int unsigned CSR_FLAG_BIT  = 5;
   localparam int unsigned CSR_IRQEN_BIT = 4;
   localparam int unsigned CSR_RUN_BIT   = 3;
   localparam int unsigned CSR_DIV_LSB   = 0;

   // event status fields
   localparam int unsigned EVT_ROLL_BIT  = 0;
   localparam int unsigned EVT_WRITE_BIT = 1;

   localparam logic [DATA_W-1:0]  COUNT_RST = 8'h00;
   localparam logic [DATA_W-1:0]  CSR_RST   = 8'h00;
   localparam logic [DATA_W-1:0]  COUNT_MAX = 8'hff;
   localparam logic [EVT_W-1:0]   EVT_RST   = 2'h0;
   localparam logic [PRESC_W-1:0] PRESC_RST = 8'h00;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tbc_pkg

// ---- hw/tbc_prescaler.sv ----
// power-of-two prescaler for the timebase counter
`timescale 1ns/10ps
module tbc_prescaler (
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   input  wire logic                          clear,
   input  wire logic                          advance,
   input  wire logic [tbc_pkg::DIV_W-1:0]     div_sel,
   output logic                               tick
);
   logic [tbc_pkg::PRESC_W-1:0] presc_reg;
   logic [tbc_pkg::PRESC_W-1:0] mask;

   // low div_sel+1 bits take part in the terminal count
   genvar i;
   generate
      for (i = 0; i < tbc_pkg::PRESC_W; i++) begin : g_mask
         assign mask[i] = (i <= int'(div_sel));
      end
   endgenerate

   // held in reset while stopped, frozen while halted
   always_ff @(posedge aclk) begin
      if (!aresetn || clear) begin
         presc_reg <= tbc_pkg::PRESC_RST;
      end else if (advance) begin
         presc_reg <= presc_reg + 8'h01;
      end
   end

   assign tick = advance && !clear && ((presc_reg & mask) == mask);

   a_tick_period: assert property (@(posedge aclk) disable iff (!aresetn)
      tick && div_sel == 3'h0 && advance && !clear ##1 advance && !clear
      && $stable(div_sel) |-> !tick)
      else $error("prescaler ticked on consecutive cycles at divide by 2");
endmodule : tbc_prescaler

// ---- hw/tbc_timebase.sv ----
// timebase counter top with axi4-lite register slave
`timescale 1ns/10ps
module tbc_timebase (
   input  wire logic                         aclk,
   input  wire logic                         aresetn,
   // axi4-lite slave
   input  wire logic [tbc_pkg::ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic                         s_axi_awvalid,
   output logic                              s_axi_awready,
   input  wire logic [31:0]                  s_axi_wdata,
   input  wire logic [3:0]                   s_axi_wstrb,
   input  wire logic                         s_axi_wvalid,
   output logic                              s_axi_wready,
   output logic [1:0]                        s_axi_bresp,
   output logic                              s_axi_bvalid,
   input  wire logic                         s_axi_bready,
   input  wire logic [tbc_pkg::ADDR_W-1:0]   s_axi_araddr,
   input  wire logic                         s_axi_arvalid,
   output logic                              s_axi_arready,
   output logic [31:0]                       s_axi_rdata,
   output logic [1:0]                        s_axi_rresp,
   output logic                              s_axi_rvalid,
   input  wire logic                         s_axi_rready,
   // auto-reload timer low byte and its counting clock
   input  wire logic                         art_tick,
   input  wire logic [tbc_pkg::DATA_W-1:0]   art_low_count,
   // system state
   input  wire logic                         halt_mode,
   // interrupt and count
   output logic                              irq,
   output logic [tbc_pkg::DATA_W-1:0]        count_value
);
   // write address and data holding
   logic                           aw_held_reg;
   logic [tbc_pkg::ADDR_W-1:0]     awaddr_reg;
   logic                           w_held_reg;
   logic [tbc_pkg::DATA_W-1:0]     wdata_reg;
   logic                           wlane0_reg;
   logic                           bvalid_reg;
   logic [1:0]                     bresp_reg;
   logic                           rvalid_reg;
   logic [tbc_pkg::DATA_W-1:0]     rdata_reg;
   logic [1:0]                     rresp_reg;
   logic                           rd_csr_reg;

   // block state
   logic [tbc_pkg::DATA_W-1:0]     count_reg;
   logic                           chain_reg;
   logic                           flag_reg;
   logic                           irqen_reg;
   logic                           run_reg;
   logic [tbc_pkg::DIV_W-1:0]      div_reg;

   logic                           do_write;
   logic                           wr_count;
   logic                           wr_csr;
   logic                           wr_clr;
   logic                           wr_en;
   logic                           wr_mapped;
   logic                           rd_take;
   logic                           rd_csr;
   logic                           rd_mapped;
   logic [tbc_pkg::DATA_W-1:0]     rd_value;
   logic [tbc_pkg::DATA_W-1:0]     csr_value;
   logic                           active;
   logic                           presc_tick;
   logic                           art_wrap;
   logic                           inc;
   logic                           wrap;
   logic [tbc_pkg::EVT_W-1:0]      events;
   logic [tbc_pkg::EVT_W-1:0]      evt_status;
   logic [tbc_pkg::EVT_W-1:0]      evt_enable;
   logic                           evt_irq;

   // write channel
   assign s_axi_awready = !aw_held_reg;
   assign s_axi_wready  = !w_held_reg;
   assign do_write      = aw_held_reg && w_held_reg && !bvalid_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         awaddr_reg  <= '0;
      end else if (s_axi_awvalid && !aw_held_reg) begin
         aw_held_reg <= 1'b1;
         awaddr_reg  <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_reg <= 1'b0;
         wdata_reg  <= '0;
         wlane0_reg <= 1'b0;
      end else if (s_axi_wvalid && !w_held_reg) begin
         w_held_reg <= 1'b1;
         wdata_reg  <= s_axi_wdata[tbc_pkg::DATA_W-1:0];
         wlane0_reg <= s_axi_wstrb[0];
      end else if (do_write) begin
         w_held_reg <= 1'b0;
      end
   end

   always_comb begin
      wr_mapped = 1'b1;
      case (awaddr_reg)
         tbc_pkg::COUNT_ADDR,
         tbc_pkg::CSR_ADDR,
         tbc_pkg::STAT_ADDR,
         tbc_pkg::CLR_ADDR,
         tbc_pkg::EN_ADDR:     wr_mapped = 1'b1;
         default:              wr_mapped = 1'b0;
      endcase
   end

   assign wr_count = do_write && wlane0_reg && (awaddr_reg == tbc_pkg::COUNT_ADDR);
   assign wr_csr   = do_write && wlane0_reg && (awaddr_reg == tbc_pkg::CSR_ADDR);
   assign wr_clr   = do_write && wlane0_reg && (awaddr_reg == tbc_pkg::CLR_ADDR);
   assign wr_en    = do_write && wlane0_reg && (awaddr_reg == tbc_pkg::EN_ADDR);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= tbc_pkg::RESP_OKAY;
      end else if (do_write) begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= wr_mapped ? tbc_pkg::RESP_OKAY : tbc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp  = bresp_reg;

   // read channel
   assign s_axi_arready = !rvalid_reg;
   assign rd_take       = s_axi_arvalid && !rvalid_reg;
   assign rd_csr        = rd_take && (s_axi_araddr == tbc_pkg::CSR_ADDR);

   // reserved bit 7 is a constant zero
   assign csr_value = {1'b0, chain_reg, flag_reg, irqen_reg, run_reg, div_reg};

   always_comb begin
      rd_value  = '0;
      rd_mapped = 1'b1;
      case (s_axi_araddr)
         tbc_pkg::COUNT_ADDR: rd_value = count_reg;
         tbc_pkg::CSR_ADDR:   rd_value = csr_value;
         tbc_pkg::STAT_ADDR:  rd_value = {{(tbc_pkg::DATA_W-tbc_pkg::EVT_W){1'b0}}, evt_status};
         tbc_pkg::CLR_ADDR:   rd_value = '0;
         tbc_pkg::EN_ADDR:    rd_value = {{(tbc_pkg::DATA_W-tbc_pkg::EVT_W){1'b0}}, evt_enable};
         default:             rd_mapped = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= '0;
         rresp_reg  <= tbc_pkg::RESP_OKAY;
         rd_csr_reg <= 1'b0;
      end else if (rd_take) begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= rd_value;
         rresp_reg  <= rd_mapped ? tbc_pkg::RESP_OKAY : tbc_pkg::RESP_SLVERR;
         rd_csr_reg <= rd_csr;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata  = {24'h000000, rdata_reg};
   assign s_axi_rresp  = rresp_reg;

   // control fields
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chain_reg <= tbc_pkg::CSR_RST[tbc_pkg::CSR_CHAIN_BIT];
         irqen_reg <= tbc_pkg::CSR_RST[tbc_pkg::CSR_IRQEN_BIT];
         run_reg   <= tbc_pkg::CSR_RST[tbc_pkg::CSR_RUN_BIT];
         div_reg   <= tbc_pkg::CSR_RST[tbc_pkg::CSR_DIV_LSB +: tbc_pkg::DIV_W];
      end else if (wr_csr) begin
         chain_reg <= wdata_reg[tbc_pkg::CSR_CHAIN_BIT];
         irqen_reg <= wdata_reg[tbc_pkg::CSR_IRQEN_BIT];
         run_reg   <= wdata_reg[tbc_pkg::CSR_RUN_BIT];
         div_reg   <= wdata_reg[tbc_pkg::CSR_DIV_LSB +: tbc_pkg::DIV_W];
      end
   end

   // counting
   assign active = run_reg && !halt_mode;

   tbc_prescaler u_presc (
      .aclk    (aclk),
      .aresetn (aresetn),
      .clear   (!run_reg),
      .advance (active && !chain_reg),
      .div_sel (div_reg),
      .tick    (presc_tick)
   );

   assign art_wrap = art_tick && (art_low_count == tbc_pkg::COUNT_MAX);
   assign inc      = active && (chain_reg ? art_wrap : presc_tick);
   assign wrap     = inc && !wr_count && (count_reg == tbc_pkg::COUNT_MAX);

   // software write wins over an increment in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_reg <= tbc_pkg::COUNT_RST;
      end else if (wr_count) begin
         count_reg <= wdata_reg;
      end else if (inc) begin
         count_reg <= count_reg + 8'h01;
      end
   end

   // set by wrap only; read clears; set wins over clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_reg <= tbc_pkg::CSR_RST[tbc_pkg::CSR_FLAG_BIT];
      end else begin
         flag_reg <= wrap || (flag_reg && !rd_csr);
      end
   end

   assign count_value = count_reg;

   // events and interrupt
   assign events[tbc_pkg::EVT_ROLL_BIT]  = wrap;
   assign events[tbc_pkg::EVT_WRITE_BIT] = wr_count && run_reg;

   tbc_event_irq u_evt (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .events   (events),
      .clr_we   (wr_clr),
      .clr_data (wdata_reg[tbc_pkg::EVT_W-1:0]),
      .en_we    (wr_en),
      .en_data  (wdata_reg[tbc_pkg::EVT_W-1:0]),
      .status   (evt_status),
      .enable   (evt_enable),
      .irq      (evt_irq)
   );

   assign irq = (flag_reg && irqen_reg) || evt_irq;

   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_frozen_count: assert property (
      !run_reg && !wr_count |=> $stable(count_reg))
      else $error("count moved while stopped");

   a_halt_freeze: assert property (
      halt_mode && !wr_count |=> count_reg == $past(count_reg))
      else $error("count moved during halt");

   a_count_step: assert property (
      inc && !wr_count |=> count_reg == 8'($past(count_reg) + 8'h01))
      else $error("count did not step by one");

   a_write_loads: assert property (
      wr_count |=> count_reg == $past(wdata_reg))
      else $error("written count not loaded");

   a_wrap_flag: assert property (
      inc && !wr_count && count_reg == 8'hff |=> flag_reg && count_reg == 8'h00)
      else $error("wrap did not set flag");

   a_flag_read_clear: assert property (
      rd_csr && !wrap |=> !flag_reg)
      else $error("status read did not clear flag");

   a_flag_write_kept: assert property (
      wr_csr && !rd_csr && !wrap |=> flag_reg == $past(flag_reg))
      else $error("write changed the flag");

   a_irq_level: assert property (
      flag_reg && irqen_reg && !rd_csr && !wr_csr |=> irq)
      else $error("interrupt dropped while flag and enable set");

   a_rsvd_zero: assert property (
      rvalid_reg && rd_csr_reg |-> !s_axi_rdata[tbc_pkg::CSR_RSVD_BIT])
      else $error("reserved bit read as one");

   a_chain_hold: assert property (
      chain_reg && !art_wrap && !wr_count |=> $stable(count_reg))
      else $error("chained count moved without low byte wrap");

   a_flag_no_spur: assert property (
      !flag_reg && !wrap |=> !flag_reg)
      else $error("flag set without a wrap");

   a_restart_clean: assert property (
      $rose(run_reg) |-> !presc_tick)
      else $error("prescaler not reset when run was set");

   a_unchained_idle: assert property (
      !chain_reg && !presc_tick && !wr_count |=> $stable(count_reg))
      else $error("count moved without a prescaler tick");

   a_chain_step: assert property (
      active && chain_reg && art_wrap && !wr_count
      |=> count_reg == 8'($past(count_reg) + 8'h01))
      else $error("chained count missed a low byte wrap");

   a_wrap_irq: assert property (
      wrap && irqen_reg && !wr_csr |=> irq)
      else $error("wrap with interrupt enabled raised no request");

   a_chain_write: assert property (
      wr_csr |=> chain_reg == $past(wdata_reg[tbc_pkg::CSR_CHAIN_BIT]))
      else $error("chain bit not written");

   a_irqen_write: assert property (
      wr_csr |=> irqen_reg == $past(wdata_reg[tbc_pkg::CSR_IRQEN_BIT]))
      else $error("interrupt enable not written");

   a_run_write: assert property (
      wr_csr |=> run_reg == $past(wdata_reg[tbc_pkg::CSR_RUN_BIT]))
      else $error("run bit not written");

   a_div_write: assert property (
      wr_csr |=> div_reg == $past(wdata_reg[tbc_pkg::CSR_DIV_LSB +: tbc_pkg::DIV_W]))
      else $error("divider select not written");

   a_count_read: assert property (
      rd_take && s_axi_araddr == tbc_pkg::COUNT_ADDR
      |=> s_axi_rdata[tbc_pkg::DATA_W-1:0] == $past(count_reg))
      else $error("count read returned a stale value");

   a_bresp_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before it was taken");

   c_wrap_irq: cover property (wrap && irqen_reg ##1 irq);
   c_chain_step: cover property (chain_reg && inc);
   c_read_clear: cover property (flag_reg && rd_csr ##1 !flag_reg);
   c_write_running: cover property (wr_count && run_reg && inc);
endmodule : tbc_timebase

// ---- verification/tbc_testbench.sv ----
// self-checking testbench for the timebase counter
`timescale 1ns/10ps
module testbench;
   localparam int unsigned LIMIT = 20000;
   logic        aclk;
   logic        aresetn;
   logic [7:0]  s_axi_awaddr;
   logic        s_axi_awvalid;
   logic        s_axi_awready;
   logic [31:0] s_axi_wdata;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_wvalid;
   logic        s_axi_wready;
   logic [1:0]  s_axi_bresp;
   logic        s_axi_bvalid;
   logic        s_axi_bready;
   logic [7:0]  s_axi_araddr;
   logic        s_axi_arvalid;
   logic        s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_rvalid;
   logic        s_axi_rready;
   logic        art_tick;
   logic [7:0]  art_low_count;
   logic        halt_mode;
   logic        irq;
   logic [7:0]  count_value;
   logic [31:0] cyc = 32'h0;
   logic [31:0] t1;
   logic [31:0] t2;
   logic [7:0]  c;
   int          mismatches;
   int          checks;

   tbc_timebase u_tbc_timebase (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .art_tick      (art_tick),
      .art_low_count (art_low_count),
      .halt_mode     (halt_mode),
      .irq           (irq),
      .count_value   (count_value)
   );

   initial begin
      aclk = 1'h0;
      forever #4 aclk = ~aclk;
   end

   task automatic close_out;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : close_out

   always @(posedge aclk) begin
      cyc <= cyc + 32'h1;
      if (cyc == LIMIT) begin
         mismatches++;
         close_out();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      logic aw_hs;
      logic w_hs;
      logic b_hs;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'h1;
      s_axi_wdata   <= {24'h000000, d};
      s_axi_wvalid  <= 1'h1;
      s_axi_bready  <= 1'h1;
      b_hs = 1'h0;
      while (!b_hs) begin
         @(negedge aclk);
         aw_hs = s_axi_awvalid & s_axi_awready;
         w_hs  = s_axi_wvalid & s_axi_wready;
         b_hs  = s_axi_bvalid & s_axi_bready;
         if (b_hs) chk({30'h0, s_axi_bresp}, {30'h0, er});
         @(posedge aclk);
         if (aw_hs) s_axi_awvalid <= 1'h0;
         if (w_hs) s_axi_wvalid <= 1'h0;
         if (b_hs) s_axi_bready <= 1'h0;
      end
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
      logic ar_hs;
      logic r_hs;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready  <= 1'h1;
      r_hs = 1'h0;
      while (!r_hs) begin
         @(negedge aclk);
         ar_hs = s_axi_arvalid & s_axi_arready;
         r_hs  = s_axi_rvalid & s_axi_rready;
         if (r_hs) chk(s_axi_rdata, {24'h000000, exp});
         if (r_hs) chk({30'h0, s_axi_rresp}, {30'h0, er});
         @(posedge aclk);
         if (ar_hs) s_axi_arvalid <= 1'h0;
         if (r_hs) s_axi_rready <= 1'h0;
      end
   endtask : rd

   task automatic wait_change(output logic [31:0] t);
      logic [7:0] p;
      int         k;
      p = count_value;
      k = 0;
      do begin
         @(negedge aclk);
         k++;
      end while (count_value === p && k < 600);
      t = cyc;
   endtask : wait_change

   task automatic pulse(input logic [7:0] low);
      @(posedge aclk);
      art_tick      <= 1'h1;
      art_low_count <= low;
      @(posedge aclk);
      art_tick      <= 1'h0;
      repeat (2) @(negedge aclk);
   endtask : pulse

   initial begin
      mismatches = 0; checks = 0;
      aresetn = 1'h0; s_axi_awaddr = 8'h00; s_axi_awvalid = 1'h0;
      s_axi_wdata = 32'h0; s_axi_wstrb = 4'h1; s_axi_wvalid = 1'h0;
      s_axi_bready = 1'h0; s_axi_araddr = 8'h00; s_axi_arvalid = 1'h0;
      s_axi_rready = 1'h0; art_tick = 1'h0; art_low_count = 8'h00; halt_mode = 1'h0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      // reset values and register access
      rd(tbc_pkg::COUNT_ADDR, 8'h00, tbc_pkg::RESP_OKAY);
      rd(tbc_pkg::CSR_ADDR, 8'h00, tbc_pkg::RESP_OKAY);
      rd(tbc_pkg::EN_ADDR, 8'h00, tbc_pkg::RESP_OKAY);
      chk({31'h0, irq}, 32'h0);
      wr(tbc_pkg::CSR_ADDR, 8'ha7, tbc_pkg::RESP_OKAY);
      rd(tbc_pkg::CSR_ADDR, 8'h07, tbc_pkg::RESP_OKAY);
      // every divider code
      for (int d = 0; d < 8; d++) begin
         wr(tbc_pkg::COUNT_ADDR, 8'h00, tbc_pkg::RESP_OKAY);
         wr(tbc_pkg::CSR_ADDR, 8'h08 | 8'(d), tbc_pkg::RESP_OKAY);
         wait_change(t1);
         wait_change(t2);
         chk(t2 - t1, 32'h1 << (d + 1));
      end
      // stop freezes count and resets prescaler, restart resumes
      wr(tbc_pkg::CSR_ADDR, 8'h00, tbc_pkg::RESP_OKAY);
      c = count_value;
      repeat (20) @(negedge aclk);
      chk({24'h0, count_value}, {24'h0, c});
      wr(tbc_pkg::CSR_ADDR, 8'h0f, tbc_pkg::RESP_OKAY);
      rd(tbc_pkg::COUNT_ADDR, c, tbc_pkg::RESP_OKAY);
      repeat (245) @(negedge aclk);
      chk({24'h0, count_value}, {24'h0, c});
      repeat (12) @(negedge aclk);
      chk({24'h0, count_value}, {24'h0, c + 8'h01});
      // write while counting
      wr(tbc_pkg::CSR_ADDR, 8'h08, tbc_pkg::RESP_OKAY);
      wr(tbc_pkg::COUNT_ADDR, 8'h80, tbc_pkg::RESP_OKAY);
      chk({31'h0, count_value inside {8'h80, 8'h81, 8'h82}}, 32'h1);
      // halt freezes, release resumes
      @(posedge aclk);
      halt_mode <= 1'h1;
      repeat (2) @(negedge aclk);
      c = count_value;
      repeat (20) @(negedge aclk);
      chk({24'h0, count_value}, {24'h0, c});
      @(posedge aclk);
      halt_mode <= 1'h0;
      repeat (10) @(negedge aclk);
      chk({31'h0, count_value != c}, 32'h1);
      // wrap sets flag and interrupt level
      wr(tbc_pkg::COUNT_ADDR, 8'hfd, tbc_pkg::RESP_OKAY);
      wr(tbc_pkg::CSR_ADDR, 8'h18, tbc_pkg::RESP_OKAY);
      for (int k = 0; k < 50 && irq !== 1'h1; k++) @(negedge aclk);
      chk({31'h0, irq}, 32'h1);
      repeat (6) @(negedge aclk);
      chk({31'h0, irq}, 32'h1);
      wr(tbc_pkg::CSR_ADDR, 8'h98, tbc_pkg::RESP_OKAY);
      rd(tbc_pkg::CSR_ADDR, 8'h38, tbc_pkg::RESP_OKAY);
      rd(tbc_pkg::CSR_ADDR, 8'h18, tbc_pkg::RESP_OKAY);
      @(negedge aclk);
      chk({31'h0, irq}, 32'h0);
      // event status, enable and clear
      wr(tbc_pkg::CSR_ADDR, 8'h00, tbc_pkg::RESP_OKAY);
      rd(tbc_pkg::STAT_ADDR, 8'h03, tbc_pkg::RESP_OKAY);
      wr(tbc_pkg::CLR_ADDR, 8'h03, tbc_pkg::RESP_OKAY);
      rd(tbc_pkg::STAT_ADDR, 8'h00, tbc_pkg::RESP_OKAY);
      wr(tbc_pkg::EN_ADDR, 8'h01, tbc_pkg::RESP_OKAY);
      rd(tbc_pkg::EN_ADDR, 8'h01, tbc_pkg::RESP_OKAY);
      wr(tbc_pkg::COUNT_ADDR, 8'hff, tbc_pkg::RESP_OKAY);
      wr(tbc_pkg::CSR_ADDR, 8'h08, tbc_pkg::RESP_OKAY);
      for (int k = 0; k < 50 && count_value !== 8'h00; k++) @(negedge aclk);
      wr(tbc_pkg::CSR_ADDR, 8'h00, tbc_pkg::RESP_OKAY);
      rd(tbc_pkg::STAT_ADDR, 8'h01, tbc_pkg::RESP_OKAY);
      chk({31'h0, irq}, 32'h1);
      wr(tbc_pkg::EN_ADDR, 8'h00, tbc_pkg::RESP_OKAY);
      chk({31'h0, irq}, 32'h0);
      wr(tbc_pkg::EN_ADDR, 8'h01, tbc_pkg::RESP_OKAY);
      chk({31'h0, irq}, 32'h1);
      wr(tbc_pkg::CLR_ADDR, 8'h01, tbc_pkg::RESP_OKAY);
      chk({31'h0, irq}, 32'h0);
      rd(tbc_pkg::STAT_ADDR, 8'h00, tbc_pkg::RESP_OKAY);
      rd(tbc_pkg::CLR_ADDR, 8'h00, tbc_pkg::RESP_OKAY);
      rd(tbc_pkg::CSR_ADDR, 8'h20, tbc_pkg::RESP_OKAY);
      rd(tbc_pkg::CSR_ADDR, 8'h00, tbc_pkg::RESP_OKAY);
      // chained with the auto-reload timer
      wr(tbc_pkg::COUNT_ADDR, 8'h05, tbc_pkg::RESP_OKAY);
      wr(tbc_pkg::CSR_ADDR, 8'h48, tbc_pkg::RESP_OKAY);
      rd(tbc_pkg::CSR_ADDR, 8'h48, tbc_pkg::RESP_OKAY);
      repeat (40) @(negedge aclk);
      chk({24'h0, count_value}, 32'h05);
      pulse(8'h10);
      chk({24'h0, count_value}, 32'h05);
      pulse(8'hff);
      chk({24'h0, count_value}, 32'h06);
      // unmapped place
      wr(8'h00, 8'h55, tbc_pkg::RESP_SLVERR);
      rd(8'hfc, 8'h00, tbc_pkg::RESP_SLVERR);
      close_out();
   end
endmodule : testbench
